//--- design/mis_bcd_fixup.sv
`timescale 1ns/1ps
`default_nettype none
module mis_bcd_fixup
  import mis_pkg::*;
(
  // Operands.
  input wire logic [7:0] working,
  input wire logic halfCarry,
  input wire logic carryIn,
  // Results.
  output logic [7:0] adjusted,
  output logic carryOut
);
  logic lowFix;
  logic [4:0] lowSum;
  logic nibbleCarryInternal;
  logic [4:0] highBase;
  logic highFix;
  logic [4:0] highSum;

  // Low nibble gets six added when above nine or half carry is set.
  assign lowFix = (working[3:0] > BCD_LIMIT) || halfCarry;
  assign lowSum = lowFix ? ({1'b0, working[3:0]} + BCD_FIX) : {1'b0, working[3:0]};
  // The internal carry follows the documented operation: it is set when the low nibble is adjusted and half carry is clear.
  assign nibbleCarryInternal = lowFix & ~halfCarry;
  // High nibble absorbs the internal carry, then six more when needed.
  assign highBase = {1'b0, working[7:4]} + {4'h0, nibbleCarryInternal};
  assign highFix = (highBase > {1'b0, BCD_LIMIT}) || carryIn;
  assign highSum = highFix ? (highBase + BCD_FIX) : highBase;
  assign adjusted = {highSum[3:0], lowSum[3:0]};
  // Carry may only be set here, never cleared.
  assign carryOut = highFix ? 1'b1 : carryIn;
endmodule // mis_bcd_fixup
`default_nettype wire

//--- design/mis_core.sv
`timescale 1ns/1ps
`default_nettype none
module mis_core
  import mis_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write address.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core state.
  output logic sysClockRun
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_HOLD = 3'b100
  } mis_wstate_type;

  mis_wstate_type wState_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic awReady_r;
  logic wReady_r;
  logic arReady_r;
  logic [7:0] operand_r;
  logic [7:0] working_r;
  logic [7:0] result_r;
  logic [2:0] bitSel_r;
  logic carry_r;
  logic halfCarry_r;
  logic zero_r;
  logic timeOut_r;
  logic sleep_r;
  logic halted_r;
  logic memWrite_r;
  logic preclearFirst_r;
  logic preclearSecond_r;
  logic [15:0] watchdog_r;
  logic [2:0] prescale_r;
  logic clkRun_r;

  // Lane merge used for the software written operand and working byte registers.
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  // Write path: both channels captured independently, in either order.
  wire awTake = s_axi_awvalid && awReady_r;
  wire wTake = s_axi_wvalid && wReady_r;
  wire haveAw = awHeld_r || awTake;
  wire haveW = wHeld_r || wTake;
  wire [7:0] wAddr = awTake ? s_axi_awaddr : awAddr_r;
  wire [31:0] wData = wTake ? s_axi_wdata : wData_r;
  wire [3:0] wStrb = wTake ? s_axi_wstrb : wStrb_r;
  wire doWrite = (wState_r == ST_IDLE) && haveAw && haveW;
  wire wMapped = (wAddr == ADDR_CONTROL) || (wAddr == ADDR_OPERAND) ||
                 (wAddr == ADDR_WORKING) || (wAddr == ADDR_STATUS);
  wire ctrlWrite = doWrite && (wAddr == ADDR_CONTROL) && wStrb[0];
  wire [3:0] opCode = ctrlWrite ? wData[3:0] : OP_NONE;
  wire [2:0] opBit = wData[6:4];
  // Instructions are refused while powered down; only a status write wakes the core.
  wire exec = ctrlWrite && !halted_r;

  // Datapath results.
  wire [7:0] minusOne = operand_r - 8'h01;
  wire [7:0] inverted = ~operand_r;
  wire [7:0] bcdAdjusted;
  wire bcdCarry;
  wire [7:0] clrMask = ~(8'h01 << opBit);

  mis_bcd_fixup uBcd (
    .working(working_r),
    .halfCarry(halfCarry_r),
    .carryIn(carry_r),
    .adjusted(bcdAdjusted),
    .carryOut(bcdCarry)
  );

  // Preclear pairing: both halves needed before a preclear clears the watchdog; the direct clear needs neither.
  wire isFirst = exec && (opCode == OP_PRECLEAR_FIRST);
  wire isSecond = exec && (opCode == OP_PRECLEAR_SECOND);
  wire pairDone = (isFirst && preclearSecond_r) || (isSecond && preclearFirst_r);
  wire wdClear = (exec && (opCode == OP_WATCHDOG_CLEAR)) || pairDone;
  wire powerDown = exec && (opCode == OP_POWER_DOWN);
  wire statWrite = doWrite && (wAddr == ADDR_STATUS) && wStrb[0];

  // Bus handshake sequencing.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wState_r <= ST_IDLE;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= RST_BYTE;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bResp_r <= RESP_OKAY;
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
    end else begin
      if (awTake) begin
        awAddr_r <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      case (wState_r)
        ST_IDLE: begin
          if (doWrite) begin
            wState_r <= ST_RESP;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awReady_r <= 1'b0;
            wReady_r <= 1'b0;
            bResp_r <= wMapped ? RESP_OKAY : RESP_SLVERR;
          end else begin
            awHeld_r <= haveAw;
            wHeld_r <= haveW;
            awReady_r <= !haveAw;
            wReady_r <= !haveW;
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            wState_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          wState_r <= ST_IDLE;
          awReady_r <= 1'b1;
          wReady_r <= 1'b1;
        end
        default: begin
          wState_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Data registers and instruction execution.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      operand_r <= RST_BYTE;
      working_r <= RST_BYTE;
      result_r <= RST_BYTE;
      bitSel_r <= 3'h0;
      carry_r <= 1'b0;
      halfCarry_r <= 1'b0;
      zero_r <= 1'b0;
      memWrite_r <= 1'b0;
    end else begin
      if (doWrite && (wAddr == ADDR_OPERAND)) begin
        operand_r <= lane0(operand_r, wData, wStrb);
      end
      if (doWrite && (wAddr == ADDR_WORKING)) begin
        working_r <= lane0(working_r, wData, wStrb);
      end
      if (statWrite) begin
        carry_r <= wData[STAT_CARRY];
        halfCarry_r <= wData[STAT_HALF_CARRY];
      end
      if (exec) begin
        memWrite_r <= 1'b0;
        case (opCode)
          OP_BIT_CLEAR: begin
            operand_r <= operand_r & clrMask;
            result_r <= operand_r & clrMask;
            bitSel_r <= opBit;
            memWrite_r <= 1'b1;
          end
          OP_INVERT_TO_WORKING: begin
            working_r <= inverted;
            zero_r <= (inverted == RST_BYTE);
          end
          OP_BCD_FIXUP: begin
            operand_r <= bcdAdjusted;
            result_r <= bcdAdjusted;
            carry_r <= bcdCarry;
            memWrite_r <= 1'b1;
          end
          OP_MINUS_ONE_IN_MEMORY: begin
            operand_r <= minusOne;
            result_r <= minusOne;
            zero_r <= (minusOne == RST_BYTE);
            memWrite_r <= 1'b1;
          end
          OP_MINUS_ONE_TO_WORKING: begin
            // Memory byte is deliberately not written here.
            working_r <= minusOne;
            zero_r <= (minusOne == RST_BYTE);
          end
          default: begin
            result_r <= result_r;
          end
        endcase
      end
    end
  end

  // Watchdog, flags and power-down; a software clear or power-down wins over the set from hardware.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeOut_r <= 1'b0;
      sleep_r <= 1'b0;
      halted_r <= 1'b0;
      preclearFirst_r <= 1'b0;
      preclearSecond_r <= 1'b0;
      watchdog_r <= RST_WATCHDOG;
      prescale_r <= RST_PRESCALE;
      clkRun_r <= 1'b1;
    end else begin
      if (wdClear || powerDown) begin
        watchdog_r <= RST_WATCHDOG;
        prescale_r <= RST_PRESCALE;
      end else if (!halted_r) begin
        prescale_r <= prescale_r + 3'h1;
        if (prescale_r == 3'h7) begin
          watchdog_r <= watchdog_r + 16'h0001;
          if (watchdog_r == 16'hFFFF) begin
            timeOut_r <= 1'b1;
          end
        end
      end
      if (pairDone || wdClear) begin
        preclearFirst_r <= 1'b0;
        preclearSecond_r <= 1'b0;
      end else begin
        preclearFirst_r <= preclearFirst_r | isFirst;
        preclearSecond_r <= preclearSecond_r | isSecond;
      end
      if (wdClear) begin
        timeOut_r <= 1'b0;
        sleep_r <= 1'b0;
      end
      if (powerDown) begin
        sleep_r <= 1'b1;
        timeOut_r <= 1'b0;
        halted_r <= 1'b1;
        clkRun_r <= 1'b0;
      end else if (statWrite && !wData[STAT_HALTED]) begin
        halted_r <= 1'b0;
        clkRun_r <= 1'b1;
      end
    end
  end

  // Read path, one outstanding read.
  wire arTake = s_axi_arvalid && arReady_r;
  wire [31:0] statusWord = {26'h000_0000, memWrite_r, halted_r, sleep_r, timeOut_r,
                            halfCarry_r, carry_r};
  logic [31:0] rMux;
  logic rOk;
  always_comb begin
    rMux = 32'h0000_0000;
    rOk = 1'b1;
    case (s_axi_araddr)
      ADDR_CONTROL: rMux = {27'h000_0000, zero_r, bitSel_r, 1'b0};
      ADDR_OPERAND: rMux = {24'h00_0000, operand_r};
      ADDR_WORKING: rMux = {24'h00_0000, working_r};
      ADDR_STATUS: rMux = statusWord;
      ADDR_RESULT: rMux = {24'h00_0000, result_r};
      ADDR_WATCHDOG: rMux = {16'h0000, watchdog_r};
      default: rOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
      arReady_r <= 1'b1;
    end else if (arTake) begin
      rValid_r <= 1'b1;
      rData_r <= rMux;
      rResp_r <= rOk ? RESP_OKAY : RESP_SLVERR;
      arReady_r <= 1'b0;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
      arReady_r <= 1'b1;
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = (wState_r == ST_RESP);
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign sysClockRun = clkRun_r;
endmodule // mis_core
`default_nettype wire

//--- design/mis_pkg.sv
package mis_pkg;
  // Instruction selector codes on the opCode wire, taken from control register bits 3:0.
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_BIT_CLEAR = 4'h1;
  localparam logic [3:0] OP_INVERT_TO_WORKING = 4'h2;
  localparam logic [3:0] OP_BCD_FIXUP = 4'h3;
  localparam logic [3:0] OP_MINUS_ONE_IN_MEMORY = 4'h4;
  localparam logic [3:0] OP_MINUS_ONE_TO_WORKING = 4'h5;
  localparam logic [3:0] OP_WATCHDOG_CLEAR = 4'h6;
  localparam logic [3:0] OP_PRECLEAR_FIRST = 4'h7;
  localparam logic [3:0] OP_PRECLEAR_SECOND = 4'h8;
  localparam logic [3:0] OP_POWER_DOWN = 4'h9;
  // Register offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_WORKING = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h14;
  // Status register field positions.
  localparam int STAT_CARRY = 0;
  localparam int STAT_HALF_CARRY = 1;
  localparam int STAT_TIME_OUT = 2;
  localparam int STAT_SLEEP = 3;
  localparam int STAT_HALTED = 4;
  localparam int STAT_MEM_WRITE = 5;
  // Decimal adjust constants.
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [4:0] BCD_FIX = 5'h06;
  // Reset values and bus response codes.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WATCHDOG = 16'h0000;
  localparam logic [2:0] RST_PRESCALE = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- test/mis_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mis_core_chk
  import mis_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core state.
  input wire logic sysClockRun
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Both write halves taken together, and the power-down request among them.
  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence haltReq;
    wrBoth ##0 (s_axi_awaddr == ADDR_CONTROL && s_axi_wstrb[0] &&
      s_axi_wdata[3:0] == OP_POWER_DOWN && sysClockRun);
  endsequence
  // A response that is not yet taken must stand still.
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped early");
  a_b_follows: assert property (wrBoth |=> s_axi_bvalid)
    else $error("write response late");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_b_reopens: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1
    (s_axi_awready && s_axi_wready)) else $error("write channel not reopened");
  a_halt_stops: assert property (haltReq |=> !sysClockRun)
    else $error("power down left the clock running");
endmodule // mis_core_chk
bind mis_core mis_core_chk u_chk(.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .sysClockRun);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mis_pkg::*;
;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, sysClockRun;
  logic [7:0] s_axi_awaddr, s_axi_araddr, m;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, msk;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] ex;
  logic [8:0] e;
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  logic [1:0] bq[$];
  logic [31:0] seed = 32'h0000_000B;
  int fails, checked, cyc;
  mis_core u_dut(.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sysClockRun);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Decimal adjust worked out nibble by nibble, carry out in the top bit.
  function automatic logic [8:0] bcdExp(input logic [7:0] w, input logic h, c);
    logic fx;
    logic co;
    logic [3:0] lo;
    logic [4:0] hi;
    co = c;
    fx = (w[3:0] > 4'h9) || h;
    lo = fx ? w[3:0] + 4'h6 : w[3:0];
    hi = {1'b0, w[7:4]} + {4'h0, fx & ~h};
    if (hi > 5'h09 || c) begin
      hi = hi + 5'h06;
      co = 1'b1;
    end
    return {co, hi[3:0], lo};
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Readies are registers, so the level at the falling edge holds at the next rise.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      @(posedge clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge clk); while (!s_axi_bvalid);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic [31:0] mk = 32'h0000_00FF, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, x});
    mq.push_back(mk);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // Results are taken off the queues as each response is handed over.
  always @(negedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      ex = rq.pop_front();
      msk = mq.pop_front();
      check({s_axi_rresp, s_axi_rdata & msk}, {ex[33:32], ex[31:0] & msk});
    end
    if (s_axi_bvalid && s_axi_bready) begin
      check({s_axi_bresp, 32'h0000_0000}, {bq.pop_front(), 32'h0000_0000});
    end
  end
  // A hung handshake is cut short here.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = xs();
      m = v[7:0];
      v = (i == 0) ? 32'h0000_039A : xs();
      wr(ADDR_OPERAND, {24'h0, m});
      wr(ADDR_CONTROL, {25'h0, i[2:0], OP_BIT_CLEAR});
      rd(ADDR_OPERAND, {24'h0, m & ~(8'h01 << i)});
      wr(ADDR_OPERAND, {24'h0, m});
      wr(ADDR_CONTROL, {28'h0, OP_INVERT_TO_WORKING});
      rd(ADDR_WORKING, {24'h0, ~m});
      rd(ADDR_OPERAND, {24'h0, m});
      wr(ADDR_CONTROL, {28'h0, OP_MINUS_ONE_TO_WORKING});
      rd(ADDR_WORKING, {24'h0, m - 8'h01});
      rd(ADDR_OPERAND, {24'h0, m});
      wr(ADDR_CONTROL, {28'h0, OP_MINUS_ONE_IN_MEMORY});
      rd(ADDR_OPERAND, {24'h0, m - 8'h01});
      wr(ADDR_WORKING, {24'h0, v[7:0]});
      wr(ADDR_STATUS, {30'h0, v[9:8]});
      wr(ADDR_CONTROL, {28'h0, OP_BCD_FIXUP});
      e = bcdExp(v[7:0], v[9], v[8]);
      rd(ADDR_OPERAND, {24'h0, e[7:0]});
      rd(ADDR_STATUS, {30'h0, v[9], e[8]}, 32'h0000_0003);
    end
    $display("Test of data operations done");
    wr(ADDR_CONTROL, {28'h0, OP_POWER_DOWN});
    check({33'h0, sysClockRun}, 34'h0);
    rd(ADDR_STATUS, 32'h0000_0018, 32'h0000_001C);
    rd(ADDR_WATCHDOG, 32'h0000_0000, 32'h0000_FFFF);
    wr(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_CONTROL, {28'h0, OP_PRECLEAR_FIRST});
    rd(ADDR_STATUS, 32'h0000_0008, 32'h0000_001C);
    wr(ADDR_CONTROL, {28'h0, OP_PRECLEAR_SECOND});
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_001C);
    wr(ADDR_CONTROL, {28'h0, OP_POWER_DOWN});
    // An instruction sent while powered down must not run.
    wr(ADDR_CONTROL, {28'h0, OP_INVERT_TO_WORKING});
    rd(ADDR_WORKING, {24'h0, v[7:0]});
    wr(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_CONTROL, {28'h0, OP_WATCHDOG_CLEAR});
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_001C);
    $display("Test of watchdog and power down done");
    wr(8'h40, 32'h0000_00FF, RESP_SLVERR);
    rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_RESULT, 32'h0000_0055, RESP_SLVERR);
    $display("Test of refused accesses done");
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
